/* File: hw/frr_pkg.sv */
// package for the frequency correction and signal strength register bank
package frr_pkg;
  localparam int AXI_AW = 10;
  localparam int AXI_DW = 32;
  // register indices, byte address is four times the index
  localparam logic [7:0] IDX_CTRL = 8'h1e;
  localparam logic [7:0] IDX_CORR_HI = 8'h1f;
  localparam logic [7:0] IDX_CORR_LO = 8'h20;
  localparam logic [7:0] IDX_FERR_HI = 8'h21;
  localparam logic [7:0] IDX_FERR_LO = 8'h22;
  localparam logic [7:0] IDX_SS_CTRL = 8'h23;
  localparam logic [7:0] IDX_SS_CODE = 8'h24;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h30;
  localparam logic [7:0] IDX_IRQ_EN = 8'h31;
  localparam logic [7:0] IDX_IRQ_CLR = 8'h32;
  // freq_correction_control fields
  localparam int B_CORR_TRIG = 0;
  localparam int B_CORR_CLR = 1;
  localparam int B_CORR_AUTO = 2;
  localparam int B_CORR_AUTOCLR = 3;
  localparam int B_CORR_DONE = 4;
  localparam int B_FERR_TRIG = 5;
  localparam int B_FERR_DONE = 6;
  // signal_strength_control fields
  localparam int B_SS_TRIG = 0;
  localparam int B_SS_DONE = 1;
  // interrupt status fields
  localparam int IRQ_W = 3;
  localparam int IRQ_CORR = 0;
  localparam int IRQ_FERR = 1;
  localparam int IRQ_SS = 2;
  // reset values and response codes
  localparam logic [15:0] RST_CORR = 16'h0000;
  localparam logic [15:0] RST_FERR = 16'h0000;
  localparam logic [7:0] RST_SS_CODE = 8'hff;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    CORR_IDLE = 2'b00,
    CORR_RUN = 2'b01
  } frr_corr_e;

  // result word from a measurement engine, valid is a one-cycle pulse
  typedef struct packed {
    logic valid;
    logic [15:0] value;
  } frr_word_s;

  typedef struct packed {
    logic valid;
    logic [7:0] code;
  } frr_code_s;

  // receiver channel filter settings
  typedef struct packed {
    logic [2:0] offset_cancel_freq;
    logic [1:0] bw_mantissa;
    logic [2:0] bw_exponent;
  } frr_bw_s;
endpackage : frr_pkg

/* File: hw/frr_regs.sv */
// axi4-lite register bank for correction, frequency error and signal strength
`timescale 1ns/1ps
// Contract
// - error trigger bit5 launches, reads zero; done bit6
// - correction done bit4 low while running, resets 1
// - auto bit2 selects trigger or receive-entry correction
// - auto-clear bit3 zeroes value before auto run
// - clear bit1 zeroes value in receive, reads zero
// - correction trigger bit0 starts one run, reads zero
// - correction value signed 16 bit at 0x1f/0x20
// - error value signed 16 bit at 0x21/0x22
// - strength trigger bit0 at 0x23 starts, reads zero
// - strength done bit1 low while sampling, resets 1
// - strength code half-dB units, resets 0xff
// - correction run uses correction bandwidth settings
module frr_regs (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [frr_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [frr_pkg::AXI_DW-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // axi4-lite read
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [frr_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [frr_pkg::AXI_DW-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // receiver state and filter settings
  input wire logic rx_mode,
  input wire frr_pkg::frr_bw_s rx_bw_normal,
  input wire frr_pkg::frr_bw_s rx_bw_correction,
  output frr_pkg::frr_bw_s rx_bw_active,
  // measurement engines
  output logic correction_start,
  input wire frr_pkg::frr_word_s correction_result,
  output logic freq_error_start,
  input wire frr_pkg::frr_word_s freq_error_result,
  output logic signal_strength_start,
  input wire frr_pkg::frr_code_s signal_strength_result,
  // interrupt
  output logic irq
);
  import frr_pkg::*;

  function automatic logic [7:0] reg_index(input logic [AXI_AW-1:0] a);
    reg_index = a[AXI_AW-1:2];
  endfunction : reg_index

  function automatic logic is_mapped(input logic [7:0] i);
    is_mapped = (i >= IDX_CTRL && i <= IDX_SS_CODE) || (i >= IDX_IRQ_STAT && i <= IDX_IRQ_CLR);
  endfunction : is_mapped

  // bus handshake state
  logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic [7:0] widx_ff;
  logic [7:0] wbyte_ff;
  logic wlane_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [7:0] rbyte_ff;
  // block state
  logic auto_ff, autoclr_ff, rx_mode_q_ff;
  logic corr_done_ff, ferr_done_ff, ss_done_ff;
  logic corr_start_ff, ferr_start_ff, ss_start_ff;
  logic [15:0] corr_value_ff, ferr_value_ff;
  logic [7:0] ss_code_ff;
  logic [IRQ_W-1:0] stat_ff, en_ff;
  logic irq_ff;
  frr_bw_s rx_bw_ff;
  frr_corr_e corr_state_ff, nxt_corr_state;

  wire aw_hs = s_axi_awvalid & awready_ff;
  wire w_hs = s_axi_wvalid & wready_ff;
  wire ar_hs = s_axi_arvalid & arready_ff;
  wire do_write = !awready_ff & !wready_ff & !bvalid_ff;
  wire wr_ok = do_write & wlane_ff & is_mapped(widx_ff);
  wire wr_ctrl = wr_ok & (widx_ff == IDX_CTRL);
  wire wr_ss_ctrl = wr_ok & (widx_ff == IDX_SS_CTRL);
  wire wr_irq_en = wr_ok & (widx_ff == IDX_IRQ_EN);
  wire wr_irq_clr = wr_ok & (widx_ff == IDX_IRQ_CLR);
  wire [7:0] ridx = reg_index(s_axi_araddr);
  wire rx_enter = rx_mode & !rx_mode_q_ff;

  // correction launch sources
  wire corr_sw_go = wr_ctrl & wbyte_ff[B_CORR_TRIG] & !auto_ff;
  wire corr_auto_go = auto_ff & rx_enter;
  wire nxt_corr_start = corr_sw_go | corr_auto_go;
  wire corr_sw_clr = wr_ctrl & wbyte_ff[B_CORR_CLR] & rx_mode;
  wire corr_auto_clr = corr_auto_go & autoclr_ff;
  wire corr_finish = correction_result.valid & (corr_state_ff == CORR_RUN);
  wire ferr_go = wr_ctrl & wbyte_ff[B_FERR_TRIG];
  wire ferr_finish = freq_error_result.valid & !ferr_done_ff;
  wire ss_go = wr_ss_ctrl & wbyte_ff[B_SS_TRIG];
  wire ss_finish = signal_strength_result.valid & !ss_done_ff;

  always_comb begin
    nxt_corr_state = corr_state_ff;
    unique case (corr_state_ff)
      CORR_IDLE: begin
        if (nxt_corr_start) begin
          nxt_corr_state = CORR_RUN;
        end
      end
      CORR_RUN: begin
        if (nxt_corr_start) begin
          nxt_corr_state = CORR_RUN;
        end else if (corr_finish) begin
          nxt_corr_state = CORR_IDLE;
        end
      end
      default: nxt_corr_state = CORR_IDLE;
    endcase
  end

  wire nxt_corr_done = (nxt_corr_state == CORR_IDLE);
  wire nxt_ferr_done = ferr_go ? 1'b0 : (ferr_finish ? 1'b1 : ferr_done_ff);
  wire nxt_ss_done = ss_go ? 1'b0 : (ss_finish ? 1'b1 : ss_done_ff);
  wire [15:0] nxt_corr_value = (corr_sw_clr | corr_auto_clr) ? RST_CORR :
                               (corr_finish ? correction_result.value : corr_value_ff);
  wire [15:0] nxt_ferr_value = ferr_finish ? freq_error_result.value : ferr_value_ff;
  wire [7:0] nxt_ss_code = ss_finish ? signal_strength_result.code : ss_code_ff;

  // sticky events, a set in the clear cycle wins
  wire [IRQ_W-1:0] events = {ss_finish, ferr_finish, corr_finish};
  wire [IRQ_W-1:0] clr_mask = wr_irq_clr ? wbyte_ff[IRQ_W-1:0] : {IRQ_W{1'b0}};
  wire [IRQ_W-1:0] nxt_stat = (stat_ff & ~clr_mask) | events;
  wire irq_src = |(stat_ff & en_ff);

  // read data, trigger bits always zero
  wire [7:0] ctrl_rd = {1'b0, ferr_done_ff, 1'b0, corr_done_ff, autoclr_ff, auto_ff, 2'b00};
  wire [7:0] ss_ctrl_rd = {6'h00, ss_done_ff, 1'b0};
  wire [7:0] nxt_rbyte =
    (ridx == IDX_CTRL) ? ctrl_rd :
    (ridx == IDX_CORR_HI) ? corr_value_ff[15:8] :
    (ridx == IDX_CORR_LO) ? corr_value_ff[7:0] :
    (ridx == IDX_FERR_HI) ? ferr_value_ff[15:8] :
    (ridx == IDX_FERR_LO) ? ferr_value_ff[7:0] :
    (ridx == IDX_SS_CTRL) ? ss_ctrl_rd :
    (ridx == IDX_SS_CODE) ? ss_code_ff :
    (ridx == IDX_IRQ_STAT) ? {{(8-IRQ_W){1'b0}}, stat_ff} :
    (ridx == IDX_IRQ_EN) ? {{(8-IRQ_W){1'b0}}, en_ff} : BYTE_ZERO;

  // write channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
      widx_ff <= BYTE_ZERO;
      wbyte_ff <= BYTE_ZERO;
      wlane_ff <= 1'b0;
    end else begin
      if (aw_hs) begin
        awready_ff <= 1'b0;
        widx_ff <= reg_index(s_axi_awaddr);
      end
      if (w_hs) begin
        wready_ff <= 1'b0;
        wbyte_ff <= s_axi_wdata[7:0];
        wlane_ff <= s_axi_wstrb[0];
      end
      if (do_write) begin
        bvalid_ff <= 1'b1;
        bresp_ff <= is_mapped(widx_ff) ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
        awready_ff <= 1'b1;
        wready_ff <= 1'b1;
      end
    end
  end

  // read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rbyte_ff <= BYTE_ZERO;
      rresp_ff <= RESP_OKAY;
    end else if (ar_hs) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b1;
      rbyte_ff <= nxt_rbyte;
      rresp_ff <= is_mapped(ridx) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
      arready_ff <= 1'b1;
    end
  end

  // control and measurement state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      auto_ff <= 1'b0;
      autoclr_ff <= 1'b0;
      rx_mode_q_ff <= 1'b0;
      corr_state_ff <= CORR_IDLE;
      corr_done_ff <= 1'b1;
      ferr_done_ff <= 1'b0;
      ss_done_ff <= 1'b1;
      corr_start_ff <= 1'b0;
      ferr_start_ff <= 1'b0;
      ss_start_ff <= 1'b0;
      corr_value_ff <= RST_CORR;
      ferr_value_ff <= RST_FERR;
      ss_code_ff <= RST_SS_CODE;
    end else begin
      if (wr_ctrl) begin
        auto_ff <= wbyte_ff[B_CORR_AUTO];
        autoclr_ff <= wbyte_ff[B_CORR_AUTOCLR];
      end
      rx_mode_q_ff <= rx_mode;
      corr_state_ff <= nxt_corr_state;
      corr_done_ff <= nxt_corr_done;
      ferr_done_ff <= nxt_ferr_done;
      ss_done_ff <= nxt_ss_done;
      corr_start_ff <= nxt_corr_start;
      ferr_start_ff <= ferr_go;
      ss_start_ff <= ss_go;
      corr_value_ff <= nxt_corr_value;
      ferr_value_ff <= nxt_ferr_value;
      ss_code_ff <= nxt_ss_code;
    end
  end

  // interrupts and filter selection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_ff <= {IRQ_W{1'b0}};
      en_ff <= {IRQ_W{1'b0}};
      irq_ff <= 1'b0;
      rx_bw_ff <= '0;
    end else begin
      stat_ff <= nxt_stat;
      if (wr_irq_en) begin
        en_ff <= wbyte_ff[IRQ_W-1:0];
      end
      irq_ff <= irq_src;
      rx_bw_ff <= nxt_corr_done ? rx_bw_normal : rx_bw_correction;
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = {24'h000000, rbyte_ff};
  assign s_axi_rresp = rresp_ff;
  assign rx_bw_active = rx_bw_ff;
  assign correction_start = corr_start_ff;
  assign freq_error_start = ferr_start_ff;
  assign signal_strength_start = ss_start_ff;
  assign irq = irq_ff;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_ctrl_read;
    ar_hs && ridx == IDX_CTRL;
  endsequence
  sequence s_ss_ctrl_read;
    ar_hs && ridx == IDX_SS_CTRL;
  endsequence
  sequence s_auto_entry;
    auto_ff && rx_enter;
  endsequence
  sequence s_corr_result;
    corr_finish && !corr_sw_clr && !corr_auto_clr;
  endsequence

  a_ferr_launch: assert property (ferr_go |=> ferr_start_ff && !ferr_done_ff && !$past(ferr_start_ff))
    else $error("error measurement not launched");
  a_ferr_finish: assert property (ferr_finish && !ferr_go |=> ferr_done_ff && ferr_value_ff == $past(freq_error_result.value))
    else $error("error result not captured");
  a_corr_busy: assert property (corr_sw_go |=> correction_start && !corr_done_ff ##1 !correction_start)
    else $error("correction run not started");
  a_auto_entry: assert property (s_auto_entry |=> correction_start && !corr_done_ff)
    else $error("receive entry did not start correction");
  a_manual_only: assert property (auto_ff && !rx_enter |=> !correction_start)
    else $error("correction started without cause");
  a_auto_clear: assert property (s_auto_entry ##0 autoclr_ff |=> corr_value_ff == RST_CORR)
    else $error("auto clear did not zero value");
  a_sw_clear: assert property (corr_sw_clr |=> corr_value_ff == RST_CORR)
    else $error("clear in receive did not zero value");
  a_ctrl_trig_zero: assert property (s_ctrl_read |=> s_axi_rvalid && s_axi_rdata[B_CORR_TRIG] == 1'b0
    && s_axi_rdata[B_CORR_CLR] == 1'b0 && s_axi_rdata[B_FERR_TRIG] == 1'b0 && s_axi_rdata[7] == 1'b0)
    else $error("trigger or unused bit read as one");
  a_corr_capture: assert property (s_corr_result |=> corr_value_ff == $past(correction_result.value))
    else $error("correction result not captured");
  a_corr_value_rd: assert property (ar_hs && ridx == IDX_CORR_HI
    |=> s_axi_rdata[7:0] == $past(corr_value_ff[15:8]))
    else $error("correction high byte wrong");
  a_ss_trig_zero: assert property (s_ss_ctrl_read |=> s_axi_rdata[7:2] == 6'h00 && s_axi_rdata[B_SS_TRIG] == 1'b0)
    else $error("strength control unused bits not zero");
  a_ss_done: assert property (ss_go |=> !ss_done_ff && signal_strength_start ##1 !signal_strength_start)
    else $error("strength done not lowered");
  a_ss_code: assert property (ss_finish && !ss_go |=> ss_done_ff && ss_code_ff == $past(signal_strength_result.code))
    else $error("strength code not captured");
  a_bw_select: assert property (!nxt_corr_done |=> rx_bw_active == $past(rx_bw_correction))
    else $error("correction bandwidth not applied");
  a_irq_follow: assert property (irq_src |=> irq)
    else $error("interrupt not raised");
  a_irq_quiet: assert property (!irq_src |=> !irq)
    else $error("interrupt raised without enabled status");

  // stored values change only on results and clears, correction done rises at run end
  a_corr_keep: assert property (s_auto_entry ##0 (!autoclr_ff && !corr_finish && !corr_sw_clr)
    |=> corr_value_ff == $past(corr_value_ff))
    else $error("auto run without clear lost value");
  a_clear_out_rx: assert property (wr_ctrl && wbyte_ff[B_CORR_CLR] && !rx_mode && !corr_finish
    |=> corr_value_ff == $past(corr_value_ff))
    else $error("clear outside receive changed value");
  a_ferr_keep: assert property (!ferr_finish |=> ferr_value_ff == $past(ferr_value_ff))
    else $error("error value changed without result");
  a_corr_done_end: assert property (corr_finish && !nxt_corr_start |=> corr_done_ff)
    else $error("correction done not raised");

  // read path returns the stored bytes
  a_corr_lo_rd: assert property (ar_hs && ridx == IDX_CORR_LO
    |=> s_axi_rdata[7:0] == $past(corr_value_ff[7:0]))
    else $error("correction low byte wrong");
  a_ferr_rd: assert property (ar_hs && ridx == IDX_FERR_HI
    |=> s_axi_rdata[7:0] == $past(ferr_value_ff[15:8]))
    else $error("error high byte wrong");
  a_ferr_lo_rd: assert property (ar_hs && ridx == IDX_FERR_LO
    |=> s_axi_rdata[7:0] == $past(ferr_value_ff[7:0]))
    else $error("error low byte wrong");
  a_ss_code_rd: assert property (ar_hs && ridx == IDX_SS_CODE |=> s_axi_rdata[7:0] == $past(ss_code_ff))
    else $error("strength code read wrong");

  // response codes, status and filter
  a_bresp_unmapped: assert property (do_write && !is_mapped(widx_ff) |=> s_axi_bvalid && s_axi_bresp == RESP_SLVERR)
    else $error("unmapped write not refused");
  a_stat_set: assert property (|events |=> (stat_ff & $past(events)) == $past(events))
    else $error("event did not set status");
  a_bw_normal: assert property (nxt_corr_done |=> rx_bw_active == $past(rx_bw_normal))
    else $error("normal bandwidth not restored");
endmodule : frr_regs

/* File: verification/tb_frr_regs.sv */
// self-checking bench for the correction and signal strength register bank
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin num_errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module tb_frr_regs;
  import frr_pkg::*;
  logic aclk = 0, aresetn = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [AXI_AW-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [AXI_DW-1:0] s_axi_wdata = '0, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp, last_bresp;
  logic rx_mode = 0, cs, fs, ss;
  frr_bw_s bw_n = 8'h5a, bw_c = 8'ha5, bw_a;
  frr_word_s cr = '0, fr = '0;
  frr_code_s sr = '0;
  int num_errors = 0, num_checks = 0, n_cs = 0, n_fs = 0, n_ss = 0;

  frr_regs frr_regs_i (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awprot(3'h0), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'h1), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .rx_mode(rx_mode), .rx_bw_normal(bw_n), .rx_bw_correction(bw_c),
    .rx_bw_active(bw_a), .correction_start(cs), .correction_result(cr), .freq_error_start(fs),
    .freq_error_result(fr), .signal_strength_start(ss), .signal_strength_result(sr), .irq(irq)
  );

  always #12.5 aclk = ~aclk;

  // count engine start pulses
  always @(posedge aclk) begin
    n_cs <= n_cs + int'(cs);
    n_fs <= n_fs + int'(fs);
    n_ss <= n_ss + int'(ss);
  end

  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    bit a = 0;
    bit w = 0;
    @(posedge aclk);
    s_axi_awvalid <= 1; s_axi_awaddr <= {i, 2'b00};
    s_axi_wvalid <= 1; s_axi_wdata <= {24'h0, d}; s_axi_bready <= 1;
    while (!(a && w)) begin
      @(posedge aclk);
      if (!a && s_axi_awready) begin a = 1; s_axi_awvalid <= 0; end
      if (!w && s_axi_wready) begin w = 1; s_axi_wvalid <= 0; end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 0;
    last_bresp = s_axi_bresp;
  endtask : wr

  task automatic rd(input logic [7:0] i, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_arvalid <= 1; s_axi_araddr <= {i, 2'b00}; s_axi_rready <= 1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 0;
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask : rd

  task automatic ck(input logic [7:0] i, input logic [7:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(i, d, r);
    `CHK(d, {24'h0, e})
    `CHK(r, RESP_OKAY)
  endtask : ck

  // one-cycle result pulse, then let done and irq settle
  task automatic res(input int k, input logic [15:0] v);
    @(posedge aclk);
    if (k == 0) cr <= {1'b1, v}; else if (k == 1) fr <= {1'b1, v}; else sr <= {1'b1, v[7:0]};
    @(posedge aclk);
    cr.valid <= 0; fr.valid <= 0; sr.valid <= 0;
    repeat (2) @(posedge aclk);
  endtask : res

  task automatic t_reset();
    logic [31:0] d;
    logic [1:0] r;
    ck(IDX_CTRL, 8'h10);
    ck(IDX_CORR_HI, 8'h00);
    ck(IDX_CORR_LO, 8'h00);
    ck(IDX_SS_CTRL, 8'h02);
    ck(IDX_SS_CODE, 8'hff);
    rd(8'h10, d, r);
    `CHK(r, RESP_SLVERR)
    wr(8'h10, 8'hff);
    `CHK(last_bresp, RESP_SLVERR)
    `CHK(bw_a, bw_n)
  endtask : t_reset

  task automatic t_corr(input logic [15:0] v, input bit with_irq);
    int n;
    n = n_cs;
    if (with_irq) wr(IDX_IRQ_EN, 8'h07);
    wr(IDX_CTRL, 8'h01);
    ck(IDX_CTRL, 8'h00 | (with_irq ? 8'h00 : 8'h40));
    `CHK(n_cs, n + 1)
    `CHK(bw_a, bw_c)
    res(0, v);
    `CHK(irq, 1'b1)
    ck(IDX_CTRL, with_irq ? 8'h10 : 8'h50);
    ck(IDX_CORR_HI, v[15:8]);
    ck(IDX_CORR_LO, v[7:0]);
    `CHK(bw_a, bw_n)
  endtask : t_corr

  task automatic t_ferr();
    int n;
    n = n_fs;
    wr(IDX_CTRL, 8'h20);
    ck(IDX_CTRL, 8'h10);
    `CHK(n_fs, n + 1)
    res(1, 16'hfe02);
    ck(IDX_CTRL, 8'h50);
    ck(IDX_FERR_HI, 8'hfe);
    ck(IDX_FERR_LO, 8'h02);
  endtask : t_ferr

  task automatic t_ss();
    int n;
    n = n_ss;
    wr(IDX_SS_CTRL, 8'hff);
    ck(IDX_SS_CTRL, 8'h00);
    `CHK(n_ss, n + 1)
    res(2, 16'h006b);
    ck(IDX_SS_CTRL, 8'h02);
    ck(IDX_SS_CODE, 8'h6b);
    ck(IDX_IRQ_STAT, 8'h07);
    wr(IDX_IRQ_CLR, 8'h07);
    ck(IDX_IRQ_STAT, 8'h00);
    `CHK(irq, 1'b0)
  endtask : t_ss

  task automatic t_clear();
    int n;
    wr(IDX_CTRL, 8'h02);
    ck(IDX_CORR_HI, 8'h81);
    n = n_cs;
    @(posedge aclk) rx_mode <= 1;
    repeat (4) @(posedge aclk);
    `CHK(n_cs, n)
    wr(IDX_CTRL, 8'h02);
    ck(IDX_CTRL, 8'h50);
    ck(IDX_CORR_HI, 8'h00);
    ck(IDX_CORR_LO, 8'h00);
  endtask : t_clear

  task automatic t_auto();
    int n;
    t_corr(16'h1234, 0);
    @(posedge aclk) rx_mode <= 0;
    wr(IDX_CTRL, 8'h84);
    ck(IDX_CTRL, 8'h54);
    n = n_cs;
    wr(IDX_CTRL, 8'h05);
    `CHK(n_cs, n)
    @(posedge aclk) rx_mode <= 1;
    repeat (4) @(posedge aclk);
    `CHK(n_cs, n + 1)
    ck(IDX_CORR_HI, 8'h12);
    res(0, 16'h0777);
    ck(IDX_CTRL, 8'h54);
    @(posedge aclk) rx_mode <= 0;
    wr(IDX_CTRL, 8'h0c);
    @(posedge aclk) rx_mode <= 1;
    repeat (4) @(posedge aclk);
    `CHK(n_cs, n + 2)
    ck(IDX_CTRL, 8'h4c);
    ck(IDX_CORR_HI, 8'h00);
    ck(IDX_CORR_LO, 8'h00);
    res(0, 16'h0abc);
    ck(IDX_CORR_LO, 8'hbc);
  endtask : t_auto

  // short reset after the last run has finished and every register but the strength control has moved
  task automatic t_rerst();
    int n;
    @(posedge aclk) aresetn <= 0;
    @(posedge aclk) aresetn <= 1;
    n = n_cs;
    ck(IDX_CTRL, 8'h10);
    ck(IDX_CORR_LO, 8'h00);
    ck(IDX_SS_CTRL, 8'h02);
    ck(IDX_SS_CODE, 8'hff);
    ck(IDX_IRQ_STAT, 8'h00);
    `CHK(irq, 1'b0)
    `CHK(n_cs, n)
    `CHK(bw_a, bw_n)
  endtask : t_rerst

  task automatic summarize();
    $display("checks=%0d errors=%0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize

  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    t_reset();
    t_corr(16'h8123, 1);
    t_ferr();
    t_ss();
    t_clear();
    t_auto();
    t_rerst();
    summarize();
  end

  initial begin
    repeat (20000) @(posedge aclk);
    num_errors++;
    summarize();
  end
endmodule : tb_frr_regs
